/* design/core_ctrl_regs.svh */
// Offsets, field positions and reset values of the status and core control registers
`ifndef CORE_CTRL_REGS_SVH
`define CORE_CTRL_REGS_SVH

`define OFF_STATUS      8'h00
`define OFF_CORE_CTRL   8'h04
`define OFF_INT_CTRL    8'h08
`define OFF_EVT_STATUS  8'h0C
`define OFF_EVT_MASK    8'h10

`define SR_PRI_HI       7
`define SR_PRI_LO       5
`define SR_REPEAT       4
`define SR_NEG          3
`define SR_OVF          2
`define SR_ZERO         1
`define SR_CARRY        0
`define SR_SAT_A        13
`define SR_SAT_B        12
`define SR_SAT_AB       10

`define CC_SIGN_SEL     12
`define CC_TERM         11
`define CC_DEPTH_HI     10
`define CC_DEPTH_LO     8
`define CC_SAT_A_EN     7
`define CC_SAT_B_EN     6
`define CC_WR_SAT_EN    5
`define CC_SAT_MODE     4
`define CC_PRI_EXT      3
`define CC_PSV          2
`define CC_RND          1
`define CC_INT_MODE     0
`define CC_WR_MASK      16'h10F7
`define CC_RESET        16'h0020

`define IC_NEST_DIS     15

`define EV_TERM         0
`define EV_SAT          1
`define EV_OVF          2
`define EV_WIDTH        3

`define PRI_MAX         3'h7
`define ZERO16          16'h0000
`define ZERO32          32'h0000_0000

`endif

/* design/core_ctrl_pkg.sv */
// Types shared by the status and core control register bank
package core_ctrl_pkg;
    typedef struct packed {
        logic        valid;
        logic        negative;
        logic        overflow;
        logic        zero;
        logic        carry;
    } alu_flags_s;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
    } bus_req_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_WRITE = 2'b10
    } bus_state_e;
endpackage

/* design/sticky_event.sv */
// One sticky event bit: hardware set wins over write-one-to-clear
`timescale 1ns/1ns
module sticky_event (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Control
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    // State
    output logic      flag
);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (clear_pulse) begin
            flag <= 1'b0;
        end
    end
endmodule

/* design/cpu_status_core_control.sv */
// Processor status and core control register bank with AHB-Lite slave
//
// Behaviour
// RULE_01: Status bits 7..5 hold the three-bit priority level, codes 0 to 7.
// RULE_02: Priority field 7 blocks all user interrupts.
// RULE_03: Effective level is extension bit over the three status bits, adding eight.
// RULE_04: Extension bit set blocks all user interrupts regardless of low bits.
// RULE_05: With nesting disable set, software writes to the priority field are ignored.
// RULE_06: Status bit 4 reads one while a repeat loop runs.
// RULE_07: Status bit 3 follows the sign of the last flag-affecting result.
// RULE_08: Status bit 2 records signed overflow of the last result.
// RULE_09: Status bit 1 set by zero result, cleared by non-zero result.
// RULE_10: Status bit 0 records carry out of the result MSB.
// RULE_11: Combined saturation sticky; software clears only, clearing also clears both.
// RULE_12: Core control reports loop depth read-only; writing bit 11 ends loop.
// RULE_13: Extension resets zero, software clear only; write saturation resets one.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "core_ctrl_regs.svh"
module cpu_status_core_control #(
    parameter int DEPTH_W = 3
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // Core side
    input  wire core_ctrl_pkg::alu_flags_s   alu_flags,
    input  wire logic                        repeat_running,
    input  wire logic [DEPTH_W-1:0]          loop_depth,
    input  wire logic                        acc_a_saturated,
    input  wire logic                        acc_b_saturated,
    input  wire logic                        core_pri_load,
    input  wire logic [3:0]                  core_pri_value,
    output logic      [3:0]                  effective_priority,
    output logic                             user_irq_blocked,
    output logic                             loop_terminate_pulse,
    output logic      [15:0]                 core_control_out,
    // Interrupt
    output logic                             irq
);
    // Address phase capture
    core_ctrl_pkg::bus_req_s   req;
    core_ctrl_pkg::bus_state_e state;
    wire logic addr_taken = hsel && hready && htrans[1];
    wire logic do_write   = (state == core_ctrl_pkg::ST_WRITE);
    wire logic wr_accept  = addr_taken && hwrite;
    core_ctrl_pkg::bus_state_e next_state;

    // Write data phase follows every accepted write address phase
    always_comb begin
        next_state = core_ctrl_pkg::ST_IDLE;
        case (state)
            core_ctrl_pkg::ST_IDLE: begin
                next_state = wr_accept ? core_ctrl_pkg::ST_WRITE : core_ctrl_pkg::ST_IDLE;
            end
            core_ctrl_pkg::ST_WRITE: begin
                next_state = wr_accept ? core_ctrl_pkg::ST_WRITE : core_ctrl_pkg::ST_IDLE;
            end
            default: begin
                next_state = core_ctrl_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            req   <= '0;
            state <= core_ctrl_pkg::ST_IDLE;
        end else if (hready) begin
            req   <= '{sel: addr_taken, write: hwrite, addr: haddr[7:0]};
            state <= next_state;
        end
    end

    // Write decode
    wire logic wr_status = do_write && (req.addr == `OFF_STATUS);
    wire logic wr_cc     = do_write && (req.addr == `OFF_CORE_CTRL);
    wire logic wr_ic     = do_write && (req.addr == `OFF_INT_CTRL);
    wire logic wr_evs    = do_write && (req.addr == `OFF_EVT_STATUS);
    wire logic wr_evm    = do_write && (req.addr == `OFF_EVT_MASK);
    wire logic [15:0] wd = hwdata[15:0];

    // Register state
    logic [2:0]  pri_level;
    logic        neg_flag;
    logic        signed_overflow_flag;
    logic        zero_flag;
    logic        carry_flag;
    logic        acc_a_saturation_sticky;
    logic        acc_b_saturation_sticky;
    logic [15:0] cc_bits;
    logic        nesting_disable_control;
    logic [`EV_WIDTH-1:0] evt_mask;
    logic [`EV_WIDTH-1:0] evt_flags;

    wire logic combined_saturation_sticky = acc_a_saturation_sticky | acc_b_saturation_sticky;
    wire logic sat_clear = wr_status && !wd[`SR_SAT_AB];
    wire logic pri_sw_write = wr_status && !nesting_disable_control; // [RULE_05]

    // Priority field and ALU flags
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pri_level <= 3'h0;
        end else if (core_pri_load) begin
            pri_level <= core_pri_value[2:0];
        end else if (pri_sw_write) begin
            pri_level <= wd[`SR_PRI_HI:`SR_PRI_LO]; // [RULE_01] [RULE_05]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            neg_flag             <= 1'b0;
            signed_overflow_flag <= 1'b0;
            zero_flag            <= 1'b0;
            carry_flag           <= 1'b0;
        end else if (alu_flags.valid) begin
            neg_flag             <= alu_flags.negative; // [RULE_07]
            signed_overflow_flag <= alu_flags.overflow; // [RULE_08]
            zero_flag            <= alu_flags.zero;     // [RULE_09]
            carry_flag           <= alu_flags.carry;    // [RULE_10]
        end else if (wr_status) begin
            neg_flag             <= wd[`SR_NEG];
            signed_overflow_flag <= wd[`SR_OVF];
            zero_flag            <= wd[`SR_ZERO];
            carry_flag           <= wd[`SR_CARRY];
        end
    end

    // Saturation sticky bits: set by hardware, cleared only through the combined bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_a_saturation_sticky <= 1'b0;
            acc_b_saturation_sticky <= 1'b0;
        end else begin
            acc_a_saturation_sticky <= acc_a_saturated
                                       | (acc_a_saturation_sticky & !sat_clear); // [RULE_11]
            acc_b_saturation_sticky <= acc_b_saturated
                                       | (acc_b_saturation_sticky & !sat_clear); // [RULE_11]
        end
    end

    // Core control: extension bit only clears from software, core may raise it
    wire logic [15:0] cc_write_val = (wd & `CC_WR_MASK) | (cc_bits & ~`CC_WR_MASK);
    wire logic next_pri_ext = core_pri_load ? core_pri_value[3]
                            : (wr_cc ? (cc_bits[`CC_PRI_EXT] & wd[`CC_PRI_EXT])
                                     : cc_bits[`CC_PRI_EXT]); // [RULE_13]

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cc_bits <= `CC_RESET; // [RULE_13]
        end else begin
            if (wr_cc) begin
                cc_bits <= cc_write_val;
            end
            cc_bits[`CC_PRI_EXT] <= next_pri_ext;
            cc_bits[`CC_TERM]    <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            nesting_disable_control <= 1'b0;
        end else if (wr_ic) begin
            nesting_disable_control <= wd[`IC_NEST_DIS];
        end
    end

    // Event status and mask
    wire logic term_req = wr_cc && wd[`CC_TERM]; // [RULE_12]
    wire logic [`EV_WIDTH-1:0] evt_set = {alu_flags.valid && alu_flags.overflow,
                                          acc_a_saturated | acc_b_saturated,
                                          term_req};
    genvar g;
    generate
        for (g = 0; g < `EV_WIDTH; g++) begin : g_evt
            sticky_event u_evt (
                .clk_sys     (clk_sys),
                .reset_n     (reset_n),
                .set_pulse   (evt_set[g]),
                .clear_pulse (wr_evs && wd[g]),
                .flag        (evt_flags[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            evt_mask <= '0;
        end else if (wr_evm) begin
            evt_mask <= wd[`EV_WIDTH-1:0];
        end
    end

    // Read views
    wire logic [15:0] status_view = {2'b00, acc_a_saturation_sticky, acc_b_saturation_sticky,
                                     1'b0, combined_saturation_sticky, 2'b00,
                                     pri_level, repeat_running, neg_flag,
                                     signed_overflow_flag, zero_flag, carry_flag}; // [RULE_06]
    wire logic [15:0] cc_view = {cc_bits[15:11],
                                 3'(loop_depth), // [RULE_12]
                                 cc_bits[7:0]};
    wire logic [4:0] rd_sel = {addr_taken && !hwrite && haddr[7:0] == `OFF_EVT_MASK,
                               addr_taken && !hwrite && haddr[7:0] == `OFF_EVT_STATUS,
                               addr_taken && !hwrite && haddr[7:0] == `OFF_INT_CTRL,
                               addr_taken && !hwrite && haddr[7:0] == `OFF_CORE_CTRL,
                               addr_taken && !hwrite && haddr[7:0] == `OFF_STATUS};
    wire logic [15:0] rd_val = ({16{rd_sel[0]}} & status_view)
                             | ({16{rd_sel[1]}} & cc_view)
                             | ({16{rd_sel[2]}} & {nesting_disable_control, 15'h0000})
                             | ({16{rd_sel[3]}} & {13'h0000, evt_flags})
                             | ({16{rd_sel[4]}} & {13'h0000, evt_mask});

    wire logic [3:0] next_eff_pri = {next_pri_ext,
        core_pri_load ? core_pri_value[2:0]
                      : (pri_sw_write ? wd[`SR_PRI_HI:`SR_PRI_LO] : pri_level)}; // [RULE_03]

    wire logic next_blocked = next_eff_pri[3]                  // [RULE_04]
                           || (next_eff_pri[2:0] == `PRI_MAX); // [RULE_02]
    wire logic [15:0] next_cc_out = {cc_bits[15:12], 4'h0, cc_bits[7:4], next_pri_ext,
                                     cc_bits[2:0]};

    // Registered outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hrdata               <= `ZERO32;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
            effective_priority   <= 4'h0;
            user_irq_blocked     <= 1'b0;
            loop_terminate_pulse <= 1'b0;
            core_control_out     <= `CC_RESET;
            irq                  <= 1'b0;
        end else begin
            if (hready) begin
                hrdata <= {16'h0000, rd_val};
            end
            effective_priority   <= next_eff_pri; // [RULE_03]
            user_irq_blocked     <= next_blocked; // [RULE_02] [RULE_04]
            loop_terminate_pulse <= term_req; // [RULE_12]
            core_control_out     <= next_cc_out;
            irq                  <= |(evt_flags & evt_mask);
        end
    end

    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    block_at_seven_a: assert property ( // [RULE_02]
        effective_priority[2:0] == `PRI_MAX |-> user_irq_blocked)
        else $error("priority seven not blocking");
    ext_blocks_a: assert property (effective_priority[3] |-> user_irq_blocked) // [RULE_04]
        else $error("extension bit not blocking");
    eff_pri_tracks_a: assert property ( // [RULE_03]
        ##1 effective_priority == {cc_bits[`CC_PRI_EXT], pri_level})
        else $error("effective priority mismatch");
    nest_lock_a: assert property ( // [RULE_05]
        wr_status && nesting_disable_control && !core_pri_load |=> $stable(pri_level))
        else $error("priority written while locked");
    repeat_view_a: assert property (status_view[`SR_REPEAT] == repeat_running) // [RULE_06]
        else $error("repeat flag mismatch");
    alu_flags_a: assert property ( // [RULE_07] [RULE_08] [RULE_09] [RULE_10]
        alu_flags.valid |=> neg_flag == $past(alu_flags.negative)
                            && carry_flag == $past(alu_flags.carry)
                            && zero_flag == $past(alu_flags.zero)
                            && signed_overflow_flag == $past(alu_flags.overflow))
        else $error("alu flags not captured");
    sat_clear_a: assert property ( // [RULE_11]
        sat_clear && !acc_a_saturated && !acc_b_saturated |=> !combined_saturation_sticky)
        else $error("saturation clear failed");
    sat_set_a: assert property ( // [RULE_11]
        acc_a_saturated |=> acc_a_saturation_sticky [*2] or sat_clear)
        else $error("saturation not sticky");
    term_pulse_a: assert property ( // [RULE_12]
        ##1 loop_terminate_pulse == $past(term_req))
        else $error("terminate pulse wrong");
    ext_no_set_a: assert property ( // [RULE_13]
        wr_cc && !core_pri_load && !cc_bits[`CC_PRI_EXT] |=> !cc_bits[`CC_PRI_EXT])
        else $error("extension set by software");
    pri_load_a: assert property ( // [RULE_03]
        core_pri_load |=> pri_level == $past(core_pri_value[2:0])
                          && cc_bits[`CC_PRI_EXT] == $past(core_pri_value[3]))
        else $error("core priority load lost");
    pri_write_a: assert property ( // [RULE_01]
        pri_sw_write && !core_pri_load |=> pri_level == $past(wd[`SR_PRI_HI:`SR_PRI_LO]))
        else $error("priority write lost");
    ext_clear_a: assert property ( // [RULE_13]
        wr_cc && !wd[`CC_PRI_EXT] && !core_pri_load |=> !cc_bits[`CC_PRI_EXT])
        else $error("extension bit not cleared");
    depth_view_a: assert property ( // [RULE_12]
        cc_view[`CC_DEPTH_HI:`CC_DEPTH_LO] == 3'(loop_depth))
        else $error("loop depth view mismatch");
    term_reads_zero_a: assert property (!cc_view[`CC_TERM]) // [RULE_12]
        else $error("terminate bit reads one");
    term_event_a: assert property (term_req |=> evt_flags[`EV_TERM])
        else $error("terminate event not recorded");
    irq_level_a: assert property (##1 irq == $past(|(evt_flags & evt_mask)))
        else $error("interrupt level mismatch");
    write_phase_a: assert property (do_write |-> req.sel && req.write)
        else $error("write phase without write request");

    pri_write_c: cover property (pri_sw_write ##1 effective_priority == 4'h7);
    sat_c: cover property (acc_b_saturated ##1 sat_clear);
    term_c: cover property (loop_terminate_pulse);
    irq_c: cover property (irq);
    nest_c: cover property (wr_status && nesting_disable_control);
endmodule

/* test/cpu_status_core_control_tb.sv */
// Self-checking bench for the status and core control register bank
`timescale 1ns/1ns
`include "core_ctrl_regs.svh"
module cpu_status_core_control_tb;
    logic                      clk_sys;
    logic                      reset_n;
    logic                      hsel;
    logic [31:0]               haddr;
    logic [1:0]                htrans;
    logic                      hwrite;
    logic [2:0]                hsize;
    logic [31:0]               hwdata;
    wire logic                 hready;
    logic [31:0]               hrdata;
    logic                      hreadyout;
    logic                      hresp;
    core_ctrl_pkg::alu_flags_s alu_flags;
    logic                      repeat_running;
    logic [2:0]                loop_depth;
    logic                      acc_a_saturated;
    logic                      acc_b_saturated;
    logic                      core_pri_load;
    logic [3:0]                core_pri_value;
    logic [3:0]                effective_priority;
    logic                      user_irq_blocked;
    logic                      loop_terminate_pulse;
    logic [15:0]               core_control_out;
    logic                      irq;
    int                        fails;
    int                        checked;
    int                        seed;
    int                        pulses;
    logic [31:0]               rd;
    logic [3:0]                fl;

    assign hready = hreadyout;

    cpu_status_core_control #(.DEPTH_W(3)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .alu_flags(alu_flags),
        .repeat_running(repeat_running), .loop_depth(loop_depth),
        .acc_a_saturated(acc_a_saturated), .acc_b_saturated(acc_b_saturated),
        .core_pri_load(core_pri_load), .core_pri_value(core_pri_value),
        .effective_priority(effective_priority), .user_irq_blocked(user_irq_blocked),
        .loop_terminate_pulse(loop_terminate_pulse), .core_control_out(core_control_out),
        .irq(irq)
    );

    always #2 clk_sys = ~clk_sys;

    function automatic logic exp_block(input logic [3:0] lvl);
        return lvl[3] | (lvl[2:0] == 3'h7);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do begin @(posedge clk_sys); n++; end while (hready !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clk_sys); n++; end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) fails++;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        alu_flags = '0;
        repeat_running = 1'b0;
        loop_depth = 3'h0;
        acc_a_saturated = 1'b0;
        acc_b_saturated = 1'b0;
        core_pri_load = 1'b0;
        core_pri_value = 4'h0;
        fails = 0;
        checked = 0;
        seed = 5353;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, `OFF_STATUS, 32'h0);
        chk(rd, 32'h0000_0000);
        bus(1'b0, `OFF_CORE_CTRL, 32'h0);
        chk(rd, 32'h0000_0020);
        bus(1'b0, 8'hFC, 32'h0);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, `OFF_STATUS, i << 5);
            settle();
            chk(effective_priority, i);
            chk(user_irq_blocked, exp_block(i));
        end
        bus(1'b1, `OFF_INT_CTRL, 32'h0000_8000);
        bus(1'b1, `OFF_STATUS, 32'h0000_00A0);
        bus(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[7:5], 3'h7);
        bus(1'b1, `OFF_INT_CTRL, 32'h0);
        bus(1'b1, `OFF_STATUS, 32'h0000_00A0);
        bus(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[7:5], 3'h5);
        for (int i = 0; i < 10; i++) begin
            fl = (i < 2) ? {4{i[0]}} : $random(seed);
            repeat_running <= i[0];
            alu_flags <= '{1'b1, fl[3], fl[2], fl[1], fl[0]};
            @(posedge clk_sys);
            alu_flags <= '0;
            settle();
            bus(1'b0, `OFF_STATUS, 32'h0);
            chk(rd[4:0], {i[0], fl});
        end
        loop_depth <= $random(seed);
        bus(1'b1, `OFF_CORE_CTRL, 32'hFFFF_FFFF);
        pulses = 0;
        repeat (4) begin
            #1;
            pulses += loop_terminate_pulse;
            @(posedge clk_sys);
        end
        chk(pulses, 1);
        bus(1'b0, `OFF_CORE_CTRL, 32'h0);
        chk(rd, {16'h0000, 16'h10F7 | (loop_depth << 8)});
        chk(core_control_out, 32'h0000_10F7);
        @(posedge clk_sys);
        core_pri_load <= 1'b1;
        core_pri_value <= 4'hA;
        @(posedge clk_sys);
        core_pri_load <= 1'b0;
        settle();
        chk(effective_priority, 4'hA);
        chk(user_irq_blocked, 1'b1);
        bus(1'b1, `OFF_CORE_CTRL, 32'h0000_0000);
        settle();
        chk(effective_priority, 4'h2);
        chk(user_irq_blocked, 1'b0);
        bus(1'b1, `OFF_EVT_STATUS, 32'h0000_0007);
        bus(1'b1, `OFF_EVT_MASK, 32'h0);
        acc_b_saturated <= 1'b1;
        @(posedge clk_sys);
        acc_b_saturated <= 1'b0;
        settle();
        chk(irq, 1'b0);
        bus(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[13:10], 4'h5);
        bus(1'b1, `OFF_EVT_MASK, 32'h0000_0002);
        settle();
        chk(irq, 1'b1);
        bus(1'b0, `OFF_EVT_STATUS, 32'h0);
        chk(rd, 32'h0000_0002);
        bus(1'b1, `OFF_EVT_STATUS, 32'h0000_0002);
        settle();
        chk(irq, 1'b0);
        bus(1'b1, `OFF_STATUS, 32'h0000_3400);
        bus(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[13:10], 4'h5);
        bus(1'b1, `OFF_STATUS, 32'h0000_0000);
        bus(1'b0, `OFF_STATUS, 32'h0);
        chk(rd[13:10], 4'h0);
        chk(hresp, 1'b0);
        chk(hreadyout, 1'b1);
        results();
    end
endmodule
